// *** common/racd_defines.svh ***
`ifndef RACD_DEFINES_SVH
`define RACD_DEFINES_SVH
`define RACD_CMD_OFFSET   8'h00
`define RACD_CMD_RESET    8'h00
`define RACD_WEN_BIT      7
`define RACD_DIR_BIT      6
`define RACD_ADDR_MSB     5
`define RACD_ADDR_LSB     0
`define RACD_A_STATUS     6'h00
`define RACD_A_ADCMODE    6'h01
`define RACD_A_IFMODE     6'h02
`define RACD_A_CHECKSUM   6'h03
`define RACD_A_DATA       6'h04
`define RACD_A_GPIO       6'h06
`define RACD_A_ID         6'h07
`define RACD_GRP_CHAN     2'h1
`define RACD_GRP_SETUP    3'h4
`define RACD_GRP_FILT     3'h5
`define RACD_GRP_OFFS     3'h6
`define RACD_GRP_GAIN     3'h7
`endif

// *** common/racd_pkg.sv ***
package racd_pkg;
  typedef enum logic [3:0] {
    RACD_T_NONE, RACD_T_STATUS, RACD_T_ADCMODE, RACD_T_IFMODE, RACD_T_CHECKSUM,
    RACD_T_DATA, RACD_T_GPIO, RACD_T_ID, RACD_T_CHAN, RACD_T_SETUP, RACD_T_FILT,
    RACD_T_OFFS, RACD_T_GAIN
  } racd_target_e;

  typedef struct packed {
    racd_target_e target;
    logic [3:0]   index;
    logic         is_read;
    logic [5:0]   target_register_address;
  } racd_select_s;
endpackage

// *** dv/racd_host_model.sv ***
`timescale 1ns/1ps
module racd_host_model (
  // clock
  input  wire logic       core_clk_i,
  // byte stream toward the decoder
  output logic            byte_valid_o,
  output logic [7:0]      byte_o,
  output logic            phase_done_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o       = 8'h00;
    phase_done_o = 1'b0;
  end
  // idle bus shows the inverse so a stale byte never looks fresh
  task automatic send(input logic [7:0] b);
    @(posedge core_clk_i);
    byte_valid_o <= 1'b1;
    byte_o       <= b;
    @(posedge core_clk_i);
    byte_valid_o <= 1'b0;
    byte_o       <= ~b;
  endtask
  task automatic finish_phase();
    @(posedge core_clk_i);
    phase_done_o <= 1'b1;
    @(posedge core_clk_i);
    phase_done_o <= 1'b0;
  endtask
endmodule

// *** dv/test_racd_top.sv ***
`timescale 1ns/1ps
module test_racd_top;
  logic                   core_clk_i;
  logic                   srst_i;
  logic                   byte_valid_i;
  logic [7:0]             byte_i;
  logic                   phase_done_i;
  racd_pkg::racd_select_s sel_o;
  logic                   phase_active_o;
  logic                   phase_write_en_o;
  logic                   phase_read_en_o;
  logic                   cmd_reject_o;
  int                     fail_count = 0;
  int                     tests_run = 0;
  racd_pkg::racd_target_e sys_t [8] = '{racd_pkg::RACD_T_STATUS, racd_pkg::RACD_T_ADCMODE,
    racd_pkg::RACD_T_IFMODE, racd_pkg::RACD_T_CHECKSUM, racd_pkg::RACD_T_DATA,
    racd_pkg::RACD_T_NONE, racd_pkg::RACD_T_GPIO, racd_pkg::RACD_T_ID};

  racd_host_model host (.core_clk_i(core_clk_i), .byte_valid_o(byte_valid_i),
    .byte_o(byte_i), .phase_done_o(phase_done_i));
  racd_top dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .phase_done_i(phase_done_i), .sel_o(sel_o),
    .phase_active_o(phase_active_o), .phase_write_en_o(phase_write_en_o),
    .phase_read_en_o(phase_read_en_o), .cmd_reject_o(cmd_reject_o));

  function automatic racd_pkg::racd_select_s exp_sel(input logic [7:0] c);
    racd_pkg::racd_select_s s;
    s = '0;
    s.is_read = c[6];
    s.target_register_address = c[5:0];
    if (c[5:3] == 3'h0) s.target = sys_t[c[2:0]];
    else if (c[5:4] == 2'h1) begin
      s.target = racd_pkg::RACD_T_CHAN;
      s.index  = c[3:0];
    end else begin
      s.target = racd_pkg::racd_target_e'({1'b0, c[5:3]} + 4'h5);
      s.index  = {1'b0, c[2:0]};
    end
    return s;
  endfunction

  task automatic chk_sel(input racd_pkg::racd_select_s e);
    tests_run++;
    if (sel_o !== e) begin
      fail_count++;
      $display("Error %0t: sel %h expected %h", $time, sel_o, e);
    end
  endtask
  task automatic chk_bit(input logic a, input logic e);
    tests_run++;
    if (a !== e) begin
      fail_count++;
      $display("Error %0t: flag %b expected %b", $time, a, e);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [7:0] c;
    logic       rsv;
    srst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1 chk_bit(phase_active_o, 1'b0);
    // every address, both directions
    for (int i = 0; i < 128; i++) begin
      c = i[7:0];
      rsv = (c[5:0] == 6'h05) || (c[5:3] == 3'h1);
      host.send(c);
      #1 chk_bit(phase_active_o, 1'b1);
      chk_bit(cmd_reject_o, 1'b0);
      chk_bit(phase_write_en_o, !rsv && !c[6]);
      chk_bit(phase_read_en_o, !rsv && c[6]);
      if (rsv) chk_bit(sel_o.target === racd_pkg::RACD_T_NONE, 1'b1);
      else chk_sel(exp_sel(c));
      // data byte inside the phase is neither decoded nor refused, gate bit or not
      host.send({c[0], ~c[6:0]});
      #1 chk_bit(cmd_reject_o, 1'b0);
      if (!rsv) chk_sel(exp_sel(c));
      host.finish_phase();
      #1 chk_bit(phase_active_o | phase_write_en_o | phase_read_en_o, 1'b0);
      chk_sel('0);
      host.send(8'h80 | c);
      #1 chk_bit(cmd_reject_o, 1'b1);
      chk_bit(phase_active_o, 1'b0);
    end
    // done pulse while waiting changes nothing
    host.finish_phase();
    #1 chk_bit(phase_active_o | cmd_reject_o, 1'b0);
    // reset in mid phase drops the open selection
    host.send(8'h50);
    #1 chk_sel(exp_sel(8'h50));
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    #1 chk_bit(phase_active_o | phase_read_en_o, 1'b0);
    chk_sel('0);
    host.send(8'h3f);
    #1 chk_bit(phase_write_en_o, 1'b1);
    chk_sel(exp_sel(8'h3f));
    host.finish_phase();
    #1 chk_bit(phase_active_o, 1'b0);
    end_of_test();
  end
endmodule

// *** hdl/racd_addr_decode.sv ***
`timescale 1ns/1ps
`include "racd_defines.svh"
module racd_addr_decode (
  // address in
  input  wire logic [5:0]   addr_i,
  // decoded target
  output racd_pkg::racd_target_e target_o,
  output logic [3:0]             index_o
);
  always_comb begin
    target_o = racd_pkg::RACD_T_NONE;
    index_o  = 4'h0;
    case (addr_i)
      `RACD_A_STATUS:   target_o = racd_pkg::RACD_T_STATUS;
      `RACD_A_ADCMODE:  target_o = racd_pkg::RACD_T_ADCMODE;
      `RACD_A_IFMODE:   target_o = racd_pkg::RACD_T_IFMODE;
      `RACD_A_CHECKSUM: target_o = racd_pkg::RACD_T_CHECKSUM;
      `RACD_A_DATA:     target_o = racd_pkg::RACD_T_DATA;
      `RACD_A_GPIO:     target_o = racd_pkg::RACD_T_GPIO;
      `RACD_A_ID:       target_o = racd_pkg::RACD_T_ID;
      default: begin
        if (addr_i[5:4] == `RACD_GRP_CHAN) begin
          target_o = racd_pkg::RACD_T_CHAN;
          index_o  = addr_i[3:0];
        end else if (addr_i[5:3] == `RACD_GRP_SETUP) begin
          target_o = racd_pkg::RACD_T_SETUP;
          index_o  = {1'b0, addr_i[2:0]};
        end else if (addr_i[5:3] == `RACD_GRP_FILT) begin
          target_o = racd_pkg::RACD_T_FILT;
          index_o  = {1'b0, addr_i[2:0]};
        end else if (addr_i[5:3] == `RACD_GRP_OFFS) begin
          target_o = racd_pkg::RACD_T_OFFS;
          index_o  = {1'b0, addr_i[2:0]};
        end else if (addr_i[5:3] == `RACD_GRP_GAIN) begin
          target_o = racd_pkg::RACD_T_GAIN;
          index_o  = {1'b0, addr_i[2:0]};
        end
        // 0x05 and 0x08-0x0f stay NONE: reserved
      end
    endcase
  end
endmodule

// *** hdl/racd_top.sv ***
`timescale 1ns/1ps
`include "racd_defines.svh"
module racd_top (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 srst_i,
  // byte stream from serial front end
  input  wire logic                 byte_valid_i,
  input  wire logic [7:0]           byte_i,
  input  wire logic                 phase_done_i,
  // decoded selection for data phase
  output racd_pkg::racd_select_s    sel_o,
  output logic                      phase_active_o,
  output logic                      phase_write_en_o,
  output logic                      phase_read_en_o,
  output logic                      cmd_reject_o
);
  typedef enum logic [0:0] {RACD_S_IDLE, RACD_S_PHASE} racd_state_e;

  racd_state_e            state, next_state;
  racd_pkg::racd_select_s next_sel;
  logic                   next_active, next_wr, next_rd, next_rej;
  racd_pkg::racd_target_e dec_target;
  logic [3:0]             dec_index;
  logic                   cmd_ok;

  racd_addr_decode u_dec (
    .addr_i   (byte_i[`RACD_ADDR_MSB:`RACD_ADDR_LSB]),
    .target_o (dec_target),
    .index_o  (dec_index)
  );

  // in idle every byte is a command byte; gate bit must be zero
  assign cmd_ok = byte_valid_i && !byte_i[`RACD_WEN_BIT];

  always_comb begin
    next_state  = state;
    next_sel    = sel_o;
    next_active = phase_active_o;
    next_wr     = phase_write_en_o;
    next_rd     = phase_read_en_o;
    next_rej    = 1'b0;
    case (state)
      RACD_S_IDLE: begin
        if (cmd_ok) begin
          next_sel.target_register_address = byte_i[`RACD_ADDR_MSB:`RACD_ADDR_LSB];
          next_sel.is_read = byte_i[`RACD_DIR_BIT];
          next_sel.target  = dec_target;
          next_sel.index   = dec_index;
          next_state  = RACD_S_PHASE;
          next_active = 1'b1;
          // reserved codes run the phase with both enables low
          next_wr = (dec_target != racd_pkg::RACD_T_NONE) && !byte_i[`RACD_DIR_BIT];
          next_rd = (dec_target != racd_pkg::RACD_T_NONE) && byte_i[`RACD_DIR_BIT];
        end else if (byte_valid_i) begin
          next_rej = 1'b1;
        end
      end
      RACD_S_PHASE: begin
        if (phase_done_i) begin
          next_state  = RACD_S_IDLE;
          next_active = 1'b0;
          next_wr     = 1'b0;
          next_rd     = 1'b0;
          next_sel    = '0; // selection holds for this transaction only
        end
      end
      default: next_state = RACD_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state            <= RACD_S_IDLE;
      sel_o            <= '0;
      phase_active_o   <= 1'b0;
      phase_write_en_o <= 1'b0;
      phase_read_en_o  <= 1'b0;
      cmd_reject_o     <= 1'b0;
    end else begin
      state            <= next_state;
      sel_o            <= next_sel;
      phase_active_o   <= next_active;
      phase_write_en_o <= next_wr;
      phase_read_en_o  <= next_rd;
      cmd_reject_o     <= next_rej;
    end
  end

  // a byte is a command only while no data phase is open
  sequence cmd_accept_s;
    !phase_active_o && byte_valid_i && !byte_i[7];
  endsequence
  sequence gated_byte_s;
    !phase_active_o && byte_valid_i && byte_i[7];
  endsequence
  sequence cmd_write_s;
    cmd_accept_s and !byte_i[6];
  endsequence
  sequence cmd_read_s;
    cmd_accept_s and byte_i[6];
  endsequence
  // unlisted codes 0x05 and 0x08-0x0f open no register
  sequence cmd_listed_s;
    cmd_accept_s and !(byte_i[5:0] == 6'h05 || byte_i[5:3] == 3'h1);
  endsequence
  sequence phase_hold_s;
    phase_active_o && !phase_done_i;
  endsequence
  sequence phase_end_s;
    phase_active_o && phase_done_i;
  endsequence
  sequence all_clear_s;
    !phase_active_o && !phase_write_en_o && !phase_read_en_o && sel_o == '0;
  endsequence

  gate_accept_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s |=> phase_active_o)
    else $error("valid command byte not accepted");
  gate_reject_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    gated_byte_s |=> !phase_active_o && cmd_reject_o)
    else $error("gated byte was not rejected");
  dir_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_write_s |=> !sel_o.is_read && !phase_read_en_o)
    else $error("write command gave read phase");
  dir_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_read_s |=> sel_o.is_read && !phase_write_en_o)
    else $error("read command gave write phase");
  addr_latch_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s |=> sel_o.target_register_address == $past(byte_i[5:0]))
    else $error("address not latched");
  addr_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_hold_s |=> $stable(sel_o))
    else $error("selection changed mid phase");
  chan_index_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:4] == 2'h1 |=>
      sel_o.target == racd_pkg::RACD_T_CHAN && sel_o.index == $past(byte_i[3:0]))
    else $error("channel decode wrong");
  gain_index_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:3] == 3'h7 |=>
      sel_o.target == racd_pkg::RACD_T_GAIN && sel_o.index == {1'b0, $past(byte_i[2:0])})
    else $error("gain decode wrong");
  reserved_idle_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:3] == 3'h1 |=> !phase_write_en_o && !phase_read_en_o)
    else $error("reserved code enabled a phase");
  phase_end_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_end_s |=> all_clear_s)
    else $error("did not return to command wait");
  reserved_five_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h05 |=>
      phase_active_o && sel_o.target == racd_pkg::RACD_T_NONE && !phase_write_en_o)
    else $error("reserved code 05 opened a register");
  write_en_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_listed_s and !byte_i[6] |=> phase_write_en_o && !phase_read_en_o)
    else $error("listed write command gave no write phase");
  read_en_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_listed_s and byte_i[6] |=> phase_read_en_o && !phase_write_en_o)
    else $error("listed read command gave no read phase");
  // system codes, one property each so a failure names the register
  sys_status_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h00 |=>
      sel_o.target == racd_pkg::RACD_T_STATUS && sel_o.index == 4'h0)
    else $error("status code decode wrong");
  sys_adcmode_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h01 |=>
      sel_o.target == racd_pkg::RACD_T_ADCMODE && sel_o.index == 4'h0)
    else $error("converter mode code decode wrong");
  sys_ifmode_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h02 |=>
      sel_o.target == racd_pkg::RACD_T_IFMODE && sel_o.index == 4'h0)
    else $error("interface mode code decode wrong");
  sys_checksum_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h03 |=>
      sel_o.target == racd_pkg::RACD_T_CHECKSUM && sel_o.index == 4'h0)
    else $error("checksum code decode wrong");
  sys_data_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h04 |=>
      sel_o.target == racd_pkg::RACD_T_DATA && sel_o.index == 4'h0)
    else $error("result code decode wrong");
  sys_gpio_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h06 |=>
      sel_o.target == racd_pkg::RACD_T_GPIO && sel_o.index == 4'h0)
    else $error("pin config code decode wrong");
  sys_id_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:0] == 6'h07 |=>
      sel_o.target == racd_pkg::RACD_T_ID && sel_o.index == 4'h0)
    else $error("identification code decode wrong");
  setup_index_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:3] == 3'h4 |=>
      sel_o.target == racd_pkg::RACD_T_SETUP && sel_o.index == {1'b0, $past(byte_i[2:0])})
    else $error("setup decode wrong");
  filt_index_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:3] == 3'h5 |=>
      sel_o.target == racd_pkg::RACD_T_FILT && sel_o.index == {1'b0, $past(byte_i[2:0])})
    else $error("filter decode wrong");
  offs_index_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_accept_s and byte_i[5:3] == 3'h6 |=>
      sel_o.target == racd_pkg::RACD_T_OFFS && sel_o.index == {1'b0, $past(byte_i[2:0])})
    else $error("offset decode wrong");
  enables_excl_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_write_en_o |-> !phase_read_en_o)
    else $error("write and read enables both high");
  enable_phase_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_write_en_o || phase_read_en_o |-> phase_active_o)
    else $error("enable high outside a phase");
  reject_idle_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cmd_reject_o |-> !phase_active_o)
    else $error("refused byte opened a phase");
  idle_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !phase_active_o |-> all_clear_s)
    else $error("selection kept outside its transaction");
  phase_stay_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_hold_s |=> phase_active_o)
    else $error("phase ended without done");
  data_no_reject_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    phase_active_o && byte_valid_i |=> !cmd_reject_o)
    else $error("data byte treated as command");
  idle_done_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !phase_active_o && phase_done_i && !byte_valid_i |=> all_clear_s)
    else $error("done pulse while waiting changed state");
  // no disable here: this one watches the reset itself
  reset_clear_a: assert property (@(posedge core_clk_i)
    srst_i |=> all_clear_s and !cmd_reject_o)
    else $error("reset left outputs set");
endmodule
